// *** rtl/lcd_port_pkg.sv ***
// Constants and types shared by the display host port modules
package lcd_port_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int PCLK_KHZ = 10000;
  localparam int NOMINAL_OSC_KHZ = 270;
  localparam int EXEC_TIME_NS = 37000;
  localparam int PTR_UPDATE_NS = 5500;
  // Oscillator ticks in one nominal instruction, rounded up
  localparam int EXEC_OSC_TICKS =
    (EXEC_TIME_NS * NOMINAL_OSC_KHZ + 999999) / 1000000;
  // Delay from busy release to the pointer step, rounded up
  localparam int PTR_UPDATE_CYCLES =
    (PTR_UPDATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Clock cycles per oscillator tick at nominal frequency
  localparam logic [15:0] OSC_DIV_RESET =
    16'(PCLK_KHZ / NOMINAL_OSC_KHZ);

  // Register byte offsets
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] OSC_DIV_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;

  // Field positions
  localparam int CTRL_LOW_POWER_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WIDTH_BIT = 1;
  localparam int STAT_PHASE_BIT = 2;
  localparam int STAT_UP_BIT = 3;
  localparam int STAT_STEP_BIT = 4;
  localparam int STAT_ONE_LINE_BIT = 5;
  localparam int STAT_PTR_LSB = 8;

  // Reset values
  localparam logic BUS_WIDTH_RESET = 1'b1;
  localparam logic LOW_POWER_RESET = 1'b0;
  localparam logic DIR_UP_RESET = 1'b1;
  localparam logic ONE_LINE_RESET = 1'b1;
  localparam logic [6:0] PTR_RESET = 7'h00;

  // Instruction decode positions
  localparam int INS_DDADDR_BIT = 7;
  localparam int INS_CGADDR_BIT = 6;
  localparam int INS_FUNC_BIT = 5;
  localparam int INS_ENTRY_BIT = 2;
  localparam int FUNC_WIDTH_BIT = 4;
  localparam int FUNC_N_BIT = 3;
  localparam int ENTRY_ID_BIT = 1;

  typedef enum logic [1:0] {
    OP_INSTR_WRITE,
    OP_DATA_WRITE,
    OP_DATA_READ,
    OP_NONE
  } op_type;

endpackage

// *** rtl/ram_port_if.sv ***
// Port between the host port and its text and glyph memory
`timescale 1ns/10ps
`default_nettype none
interface ram_port_if #(parameter int AW = 8);
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic we;
  logic [7:0] rdata;
  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// *** rtl/text_ram.sv ***
// Text and glyph memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module text_ram #(
  parameter int AW = 8
) (
  input wire logic pclk,
  ram_port_if.mem port
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge pclk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
    port.rdata <= mem[port.addr];
  end
endmodule
`default_nettype wire

// *** rtl/exec_timer.sv ***
// Instruction execution timer counted in oscillator ticks
`timescale 1ns/10ps
`default_nettype none
module exec_timer
  import lcd_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [15:0] osc_div,
  input wire logic low_power,
  input wire logic one_line,
  output logic busy_reg
);
  logic [15:0] div_reg;
  logic [7:0] tick_reg;
  logic [7:0] target;
  logic osc_tick;

  assign osc_tick = (div_reg == 16'h0000);

  // Four times for one line, twice otherwise, in low power
  always_comb begin
    target = 8'(EXEC_OSC_TICKS);
    if (low_power) begin
      target = one_line ? 8'(EXEC_OSC_TICKS * 4) :
               8'(EXEC_OSC_TICKS * 2);
    end
  end

  // Oscillator emulation: one tick every osc_div clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 16'h0000;
    end else if (start || osc_tick) begin
      div_reg <= (osc_div == 16'h0000) ? 16'h0000 : osc_div - 16'h0001;
    end else begin
      div_reg <= div_reg - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      tick_reg <= 8'h00;
    end else if (start) begin
      busy_reg <= 1'b1;
      tick_reg <= 8'h00;
    end else if (busy_reg && osc_tick) begin
      tick_reg <= tick_reg + 8'h01;
      if (tick_reg + 8'h01 >= target) begin
        busy_reg <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/lcd_host_port.sv ***
// Display controller host port: strobed bus, pointer, width, timing
// Function
// - Data access steps pointer by one, per direction
// - Pointer steps 5.5 us after busy clears
// - Execution time scales with oscillator frequency
// - Low power, slave pin low only: four times one-line, else twice
// - Four-bit mode: two nibbles make one operation
// - Function set chooses eight or four bit width
// - Reset selects eight bit width
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module lcd_host_port
  import lcd_port_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable_strobe,
  input wire logic reg_select,
  input wire logic read_not_write,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic bus_oe,
  input wire logic slave_driver_output_pin
);
  ram_port_if #(.AW(AW)) ram_port ();

  // Pin synchronisers
  logic e_s1, e_s2, e_s3;
  logic rs_s1, rs_s2;
  logic rw_s1, rw_s2;
  logic slave_pin_s1, slave_pin_s2;
  logic [7:0] db_s1, db_s2;

  // Control state
  logic bus_width_select;
  logic one_line_reg;
  logic dir_up_reg;
  logic low_power_select;
  logic [15:0] osc_div_reg;
  logic [6:0] ram_pointer;
  logic glyph_sel_reg;
  logic nibble_phase_reg;
  logic [3:0] high_nibble_reg;
  logic rs_reg;
  logic rw_reg;
  logic [7:0] read_byte_reg;
  logic step_pending_reg;
  logic [7:0] step_count_reg;
  logic busy_indicator;

  // Decoded strobe events
  logic e_rise;
  logic e_fall;
  logic byte_done;
  logic [7:0] full_byte;
  logic start_exec;
  op_type op;
  logic low_power_active;
  logic apb_access;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e_s1 <= 1'b0;
      e_s2 <= 1'b0;
      e_s3 <= 1'b0;
      rs_s1 <= 1'b0;
      rs_s2 <= 1'b0;
      rw_s1 <= 1'b0;
      rw_s2 <= 1'b0;
      slave_pin_s1 <= 1'b0;
      slave_pin_s2 <= 1'b0;
      db_s1 <= 8'h00;
      db_s2 <= 8'h00;
    end else begin
      e_s1 <= enable_strobe;
      e_s2 <= e_s1;
      e_s3 <= e_s2;
      rs_s1 <= reg_select;
      rs_s2 <= rs_s1;
      rw_s1 <= read_not_write;
      rw_s2 <= rw_s1;
      slave_pin_s1 <= slave_driver_output_pin;
      slave_pin_s2 <= slave_pin_s1;
      db_s1 <= bus_in;
      db_s2 <= db_s1;
    end
  end

  assign e_rise = e_s2 && !e_s3;
  assign e_fall = !e_s2 && e_s3;

  // Eight-bit mode completes on each strobe, four-bit on the second
  assign byte_done = e_fall && (bus_width_select || nibble_phase_reg);
  assign full_byte = bus_width_select ? db_s2 :
                     {high_nibble_reg, db_s2[7:4]};

  // Status reads never execute; other accesses are ignored while busy
  always_comb begin
    op = OP_NONE;
    if (byte_done && !busy_indicator) begin
      if (!rs_reg && !rw_reg) begin
        op = OP_INSTR_WRITE;
      end else if (rs_reg && !rw_reg) begin
        op = OP_DATA_WRITE;
      end else if (rs_reg && rw_reg) begin
        op = OP_DATA_READ;
      end
    end
  end

  assign start_exec = (op != OP_NONE);
  assign low_power_active = low_power_select && !slave_pin_s2;

  // Register select and direction are held from the rising strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_reg <= 1'b0;
      rw_reg <= 1'b0;
      read_byte_reg <= 8'h00;
    end else if (e_rise) begin
      rs_reg <= rs_s2;
      rw_reg <= rw_s2;
      if (!(nibble_phase_reg && !bus_width_select)) begin
        read_byte_reg <= rs_s2 ? ram_port.rdata :
                         {busy_indicator, ram_pointer};
      end
    end
  end

  // Nibble phase toggles on every strobe in four-bit mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nibble_phase_reg <= 1'b0;
      high_nibble_reg <= 4'h0;
    end else if (e_fall) begin
      if (bus_width_select) begin
        nibble_phase_reg <= 1'b0;
      end else begin
        nibble_phase_reg <= !nibble_phase_reg;
        if (!nibble_phase_reg) begin
          high_nibble_reg <= db_s2[7:4];
        end
      end
    end
  end

  // Read data driven while the strobe is high and direction is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_out <= 8'h00;
      bus_oe <= 1'b0;
    end else begin
      bus_oe <= e_s2 && rw_s2;
      if (bus_width_select) begin
        bus_out <= read_byte_reg;
      end else if (nibble_phase_reg) begin
        bus_out <= {read_byte_reg[3:0], 4'h0};
      end else begin
        bus_out <= {read_byte_reg[7:4], 4'h0};
      end
    end
  end

  // Function set, entry mode and address instructions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_width_select <= BUS_WIDTH_RESET;
      one_line_reg <= ONE_LINE_RESET;
      dir_up_reg <= DIR_UP_RESET;
    end else if (op == OP_INSTR_WRITE) begin
      if (full_byte[INS_DDADDR_BIT] || full_byte[INS_CGADDR_BIT]) begin
        bus_width_select <= bus_width_select;
      end else if (full_byte[INS_FUNC_BIT]) begin
        bus_width_select <= full_byte[FUNC_WIDTH_BIT];
        one_line_reg <= !full_byte[FUNC_N_BIT];
      end else if (full_byte[INS_ENTRY_BIT]) begin
        dir_up_reg <= full_byte[ENTRY_ID_BIT];
      end
    end
  end

  // Pointer load, and the delayed step after data accesses
  // A data access taken before a pending step lands restarts the delay,
  // so the host must wait for the step before the next access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_pointer <= PTR_RESET;
      glyph_sel_reg <= 1'b0;
      step_pending_reg <= 1'b0;
      step_count_reg <= 8'h00;
    end else if (op == OP_INSTR_WRITE && full_byte[INS_DDADDR_BIT]) begin
      ram_pointer <= full_byte[6:0];
      glyph_sel_reg <= 1'b0;
      step_pending_reg <= 1'b0;
    end else if (op == OP_INSTR_WRITE && full_byte[INS_CGADDR_BIT]) begin
      ram_pointer <= {1'b0, full_byte[5:0]};
      glyph_sel_reg <= 1'b1;
      step_pending_reg <= 1'b0;
    end else if (op == OP_DATA_WRITE || op == OP_DATA_READ) begin
      step_pending_reg <= 1'b1;
      step_count_reg <= 8'h00;
    end else if (step_pending_reg && !busy_indicator) begin
      if (step_count_reg == 8'(PTR_UPDATE_CYCLES - 1)) begin
        step_pending_reg <= 1'b0;
        ram_pointer <= dir_up_reg ? ram_pointer + 7'h01 :
                       ram_pointer - 7'h01;
      end else begin
        step_count_reg <= step_count_reg + 8'h01;
      end
    end
  end

  // Memory port
  assign ram_port.addr = AW'({glyph_sel_reg, ram_pointer});
  assign ram_port.wdata = full_byte;
  assign ram_port.we = (op == OP_DATA_WRITE);

  // Glyph select is the top address bit of the shared memory
  text_ram #(.AW(AW)) ram_inst (
    .pclk(pclk),
    .port(ram_port.mem)
  );

  // One timer paces every accepted operation
  exec_timer timer_inst (
    .pclk(pclk),
    .presetn(presetn),
    .start(start_exec),
    .osc_div(osc_div_reg),
    .low_power(low_power_active),
    .one_line(one_line_reg),
    .busy_reg(busy_indicator)
  );

  // APB slave with one wait state
  assign apb_access = psel && penable && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_select <= LOW_POWER_RESET;
      osc_div_reg <= OSC_DIV_RESET;
    end else if (apb_access && pwrite) begin
      if (paddr == CTRL_OFFSET) begin
        low_power_select <= pwdata[CTRL_LOW_POWER_BIT];
      end else if (paddr == OSC_DIV_OFFSET) begin
        osc_div_reg <= pwdata[15:0];
      end
    end
  end

  // Read data loads on the same edge that raises pready and then holds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      if (paddr == CTRL_OFFSET) begin
        prdata[CTRL_LOW_POWER_BIT] <= low_power_select;
      end else if (paddr == OSC_DIV_OFFSET) begin
        prdata[15:0] <= osc_div_reg;
      end else if (paddr == STATUS_OFFSET) begin
        prdata[STAT_BUSY_BIT] <= busy_indicator;
        prdata[STAT_WIDTH_BIT] <= bus_width_select;
        prdata[STAT_PHASE_BIT] <= nibble_phase_reg;
        prdata[STAT_UP_BIT] <= dir_up_reg;
        prdata[STAT_STEP_BIT] <= step_pending_reg;
        prdata[STAT_ONE_LINE_BIT] <= one_line_reg;
        prdata[STAT_PTR_LSB +: 8] <= {glyph_sel_reg, ram_pointer};
      end else begin
        pslverr <= 1'b1;
      end
    end else begin
      pslverr <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** testbench/lcd_host_port_asserts.sv ***
// Checker on the host port top-level pins
`timescale 1ns/10ps
`default_nettype none
module lcd_host_port_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic enable_strobe,
  input wire logic read_not_write,
  input wire logic bus_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready high for more than one cycle");
  AST_READY_LATENCY: assert property (psel && $rose(penable) |=> pready)
    else $error("pready not one cycle into access phase");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_ERR_UNMAPPED: assert property (pready |->
    (pslverr == !(paddr inside {12'h000, 12'h004, 12'h008})))
    else $error("pslverr does not match address map");
  AST_RDATA_HOLD: assert property (!pready |-> $stable(prdata))
    else $error("prdata changed outside an answer");
  AST_OE_IDLE: assert property (!enable_strobe [*6] |-> !bus_oe)
    else $error("bus driven long after strobe fell");
  AST_OE_WRITE: assert property (!read_not_write [*6] |-> !bus_oe)
    else $error("bus driven during a write");
  AST_OE_READ: assert property ((enable_strobe && read_not_write) [*5]
    |-> bus_oe)
    else $error("bus not driven during a read strobe");
endmodule
bind lcd_host_port lcd_host_port_checker lcd_host_port_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .enable_strobe(enable_strobe), .read_not_write(read_not_write),
  .bus_oe(bus_oe));
`default_nettype wire

// *** testbench/host_model.sv ***
// Host MCU model driving the strobed display bus pins
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic pclk,
  input wire logic [7:0] bus_out,
  input wire logic bus_oe,
  output logic enable_strobe,
  output logic reg_select,
  output logic read_not_write,
  output wire logic [7:0] bus_in
);
  logic [7:0] drv = 8'h00;
  logic [7:0] last = 8'h00;
  logic host_oe = 1'b0;
  // Released bus shows the inverse of the last driven value
  assign bus_in = bus_oe ? bus_out : (host_oe ? drv : ~last);
  initial begin
    enable_strobe = 1'b0;
    reg_select = 1'b0;
    read_not_write = 1'b0;
  end
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge pclk);
    reg_select <= rs;
    read_not_write <= rw;
    drv <= d;
    host_oe <= !rw;
    enable_strobe <= 1'b1;
    repeat (6) @(posedge pclk);
    q = bus_out;
    enable_strobe <= 1'b0;
    repeat (4) @(posedge pclk);
    last <= d;
    host_oe <= 1'b0;
  endtask
  task automatic xfer_byte(input logic four, input logic rs, input logic rw,
                           input logic [7:0] d, output logic [7:0] q);
    logic [7:0] h;
    logic [7:0] l;
    if (four) begin
      xfer(rs, rw, {d[7:4], ~d[3:0]}, h);
      xfer(rs, rw, {d[3:0], ~d[3:0]}, l);
      q = {h[7:4], l[7:4]};
    end else begin
      xfer(rs, rw, d, q);
    end
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the display host port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import lcd_port_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, enable_strobe, reg_select, read_not_write, bus_oe;
  logic [7:0] bus_in, bus_out;
  logic slave_pin = 1'b1;
  logic four = 1'b0;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int ml[4] = '{1, 4, 2, 1};
  always #50 pclk = ~pclk;
  lcd_host_port lcd_host_port_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enable_strobe(enable_strobe), .reg_select(reg_select),
    .read_not_write(read_not_write), .bus_in(bus_in), .bus_out(bus_out),
    .bus_oe(bus_oe), .slave_driver_output_pin(slave_pin));
  host_model host_model_inst (.pclk(pclk), .bus_out(bus_out),
    .bus_oe(bus_oe), .enable_strobe(enable_strobe), .reg_select(reg_select),
    .read_not_write(read_not_write), .bus_in(bus_in));
  task automatic give_verdict;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stat(output logic [31:0] s);
    logic e;
    apb(1'b0, STATUS_OFFSET, 32'h0, s, e);
  endtask
  task automatic idle;
    logic [31:0] s;
    do stat(s); while (s[STAT_BUSY_BIT] !== 1'b0 || s[STAT_STEP_BIT] !== 1'b0);
  endtask
  task automatic op(input logic rs, input logic rw, input logic [7:0] d,
                    output logic [7:0] q);
    host_model_inst.xfer_byte(four, rs, rw, d, q);
    idle;
  endtask
  task automatic ptr_is(input logic [7:0] p);
    logic [31:0] s;
    stat(s);
    chk({24'h0, s[15:8]}, {24'h0, p});
  endtask
  // Busy length in cycles against 10 ticks of 4 cycles times m
  task automatic exec(input int m);
    logic [31:0] s;
    logic [7:0] q;
    int t0;
    host_model_inst.xfer_byte(four, 1'b0, 1'b0, 8'h06, q);
    t0 = cyc;
    do stat(s); while (s[STAT_BUSY_BIT] !== 1'b0);
    t0 = 40 * m - (cyc - t0);
    chk(32'(t0 > -8 && t0 < 6), 32'h1);
    idle;
  endtask
  initial begin
    logic [31:0] r;
    logic e;
    logic [7:0] q;
    int t0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFFSET, 32'h0, r, e);
    chk(r, 32'h0);
    apb(1'b0, OSC_DIV_OFFSET, 32'h0, r, e);
    chk(r, {16'h0, OSC_DIV_RESET});
    stat(r);
    chk(r, 32'h0000002a);
    apb(1'b0, 12'h00c, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, OSC_DIV_OFFSET, 32'h4, r, e);
    apb(1'b0, OSC_DIV_OFFSET, 32'h0, r, e);
    chk(r, 32'h4);
    op(1'b0, 1'b0, 8'h85, q);
    ptr_is(8'h05);
    host_model_inst.xfer_byte(four, 1'b1, 1'b0, 8'h41, q);
    do stat(r); while (r[STAT_BUSY_BIT] !== 1'b0);
    t0 = cyc;
    chk({23'h0, r[STAT_STEP_BIT], r[15:8]}, 32'h105);
    do stat(r); while (r[15:8] === 8'h05);
    t0 = cyc - t0;
    chk({23'h0, 1'(t0 > 47 && t0 < 60), r[15:8]}, 32'h106);
    op(1'b0, 1'b0, 8'h04, q);
    op(1'b0, 1'b0, 8'h85, q);
    op(1'b1, 1'b0, 8'h42, q);
    ptr_is(8'h04);
    op(1'b0, 1'b0, 8'h85, q);
    op(1'b1, 1'b1, 8'h00, q);
    chk({24'h0, q}, 32'h42);
    ptr_is(8'h04);
    op(1'b0, 1'b0, 8'h43, q);
    op(1'b1, 1'b0, 8'h1f, q);
    ptr_is(8'h82);
    op(1'b0, 1'b0, 8'h06, q);
    for (int i = 0; i < 4; i++) begin
      op(1'b0, 1'b0, (i == 2) ? 8'h38 : 8'h30, q);
      apb(1'b1, CTRL_OFFSET, {31'h0, 1'(i != 0)}, r, e);
      slave_pin <= (i == 3);
      exec(ml[i]);
    end
    apb(1'b1, CTRL_OFFSET, 32'h0, r, e);
    op(1'b0, 1'b0, 8'h20, q);
    four = 1'b1;
    stat(r);
    chk(r & 32'h6, 32'h0);
    op(1'b0, 1'b0, 8'h20, q);
    host_model_inst.xfer(1'b0, 1'b0, 8'h87, q);
    stat(r);
    chk({31'h0, r[STAT_PHASE_BIT]}, 32'h1);
    host_model_inst.xfer(1'b0, 1'b0, 8'h5a, q);
    idle;
    ptr_is(8'h05);
    op(1'b1, 1'b0, 8'h5a, q);
    op(1'b0, 1'b0, 8'h85, q);
    op(1'b1, 1'b1, 8'h00, q);
    chk({24'h0, q}, 32'h5a);
    op(1'b0, 1'b1, 8'h00, q);
    chk({24'h0, q}, 32'h06);
    op(1'b0, 1'b0, 8'h30, q);
    four = 1'b0;
    stat(r);
    chk({31'h0, r[STAT_WIDTH_BIT]}, 32'h1);
    give_verdict;
  end
endmodule
`default_nettype wire
